// ### verilog/io_space_pkg.sv
/*
  Package for the I/O space decoder: data-space offsets of the mapped
  registers, writable masks, write-one-to-clear masks and access carriers.
  Assumes one core clock and a core that issues one access per cycle.
*/
// Behaviour
// - Bit set and clear reach only I/O addresses 0x00 to 0x1F.
// - Bit test and skip works on I/O addresses 0x00 to 0x1F.
// - Flag bits clear on a written one; a written zero keeps them.
// - Bit set or clear rewrites the whole register, clearing flags read as one, except the bit that a bit clear selects.
// - Short in and out instructions carry a six-bit address, first 64 slots.
// - Data-space address of an I/O register is its I/O address plus 0x20.
// - Extended region 0x60 to 0xFF answers only load and store families.
package io_space_pkg;

  // Kind of access presented by the core
  typedef enum logic [2:0]
  {
    acc_none = 3'b000,
    acc_short_in = 3'b001,
    acc_short_out = 3'b010,
    acc_data_load = 3'b011,
    acc_data_store = 3'b100,
    acc_bit_set = 3'b101,
    acc_bit_clear = 3'b110,
    acc_bit_test = 3'b111
  } access_kind_type;

  // One request from the core; addr is I/O address for short forms
  typedef struct packed
  {
    access_kind_type kind;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } io_request_type;

  // Registered answer to the core
  typedef struct packed
  {
    logic valid;
    logic [7:0] rdata;
    logic bit_value;
    logic refused;
  } io_answer_type;

  localparam logic [7:0] io_to_data_offset = 8'h20;
  localparam logic [7:0] short_io_limit = 8'h3F;
  localparam logic [7:0] bit_access_limit = 8'h1F;
  localparam logic [7:0] extended_base = 8'h60;
  localparam logic [7:0] extended_top = 8'hFF;
  localparam int map_depth = 256;
  localparam logic [7:0] reset_value = 8'h00;

  // Data-space offset, writable bits, write-one-to-clear bits
  typedef struct packed
  {
    logic [7:0] offset;
    logic [7:0] write_mask;
    logic [7:0] w1c_mask;
  } reg_desc_type;

  localparam int reg_count = 49;

  localparam reg_desc_type reg_table [reg_count] = '{
    '{8'h20, 8'hFF, 8'h00}, // port_a_input_pins
    '{8'h21, 8'hFF, 8'h00}, // port_a_direction
    '{8'h22, 8'hFF, 8'h00}, // port_a_output_latch
    '{8'h23, 8'hFF, 8'h00}, // port_b_input_pins
    '{8'h24, 8'hFF, 8'h00}, // port_b_direction
    '{8'h25, 8'hFF, 8'h00}, // port_b_output_latch
    '{8'h28, 8'h01, 8'h00}, // port_c_output_latch
    '{8'h29, 8'h03, 8'h00}, // port_d_input_pins
    '{8'h2A, 8'h03, 8'h00}, // port_d_direction
    '{8'h2B, 8'h03, 8'h00}, // port_d_output_latch
    '{8'h35, 8'h07, 8'h07}, // timer0_flag_bits
    '{8'h36, 8'h03, 8'h03}, // timer1_flag_bits
    '{8'h3B, 8'h03, 8'h03}, // pin_change_flag_bits
    '{8'h3C, 8'h0F, 8'h0F}, // external_irq_flag_bits
    '{8'h3D, 8'h0F, 8'h00}, // external_irq_mask
    '{8'h3E, 8'hFF, 8'h00}, // scratch_register_0
    '{8'h3F, 8'h3F, 8'h00}, // nvm_data_control
    '{8'h40, 8'hFF, 8'h00}, // nvm_data_byte
    '{8'h41, 8'hFF, 8'h00}, // nvm_address_low
    '{8'h42, 8'h01, 8'h00}, // nvm_address_high
    '{8'h43, 8'h83, 8'h00}, // timer_prescaler_control
    '{8'h44, 8'hF3, 8'h00}, // timer0_control_a
    '{8'h45, 8'hCF, 8'h00}, // timer0_control_b
    '{8'h46, 8'hFF, 8'h00}, // timer0_count
    '{8'h47, 8'hFF, 8'h00}, // timer0_compare_a
    '{8'h48, 8'hFF, 8'h00}, // timer0_compare_b
    '{8'h4A, 8'hFF, 8'h00}, // scratch_register_1
    '{8'h4B, 8'hFF, 8'h00}, // scratch_register_2
    '{8'h51, 8'hFF, 8'h00}, // debug_channel_data
    '{8'h53, 8'h0F, 8'h00}, // sleep_mode_control
    '{8'h54, 8'h1F, 8'h1F}, // reset_cause_flags
    '{8'h55, 8'h93, 8'h00}, // core_misc_control
    '{8'h57, 8'hFF, 8'h00}, // self_program_control
    '{8'h5D, 8'hFF, 8'h00}, // stack_pointer_low
    '{8'h5E, 8'hFF, 8'h00}, // stack_pointer_high
    '{8'h5F, 8'hFF, 8'h00}, // core_status_flags
    '{8'h60, 8'hFF, 8'h80}, // watchdog_control
    '{8'h62, 8'hFF, 8'h80}, // wakeup_timer_control
    '{8'h64, 8'h0F, 8'h00}, // power_reduction_control
    '{8'h66, 8'hFF, 8'h00}, // fast_oscillator_trim
    '{8'h68, 8'h03, 8'h00}, // pin_change_irq_control
    '{8'h69, 8'hFF, 8'h00}, // external_irq_sense_control
    '{8'h6B, 8'hFF, 8'h00}, // pin_change_mask_low
    '{8'h6C, 8'hFF, 8'h00}, // pin_change_mask_high
    '{8'h6E, 8'h07, 8'h00}, // timer0_irq_mask
    '{8'h6F, 8'h03, 8'h00}, // timer1_irq_mask
    '{8'h78, 8'h00, 8'h00}, // voltage_conv_result_low
    '{8'h79, 8'h00, 8'h00}, // voltage_conv_result_high
    '{8'h00, 8'h00, 8'h00}  // spare slot, never matched
  };

  localparam logic [7:0] timer0_flags_offset = 8'h35;
  localparam logic [7:0] ext_irq_flags_offset = 8'h3C;
  localparam logic [7:0] conv_low_offset = 8'h78;
  localparam logic [7:0] conv_high_offset = 8'h79;
  localparam logic [7:0] ext_irq_mask_offset = 8'h3D;

endpackage : io_space_pkg

// ### verilog/io_space_address_decoder.sv
/*
  I/O space address decoder and register bank. Turns the core's short
  I/O, bit and data-space accesses into register reads and writes.
  Assumes the core holds no request while the answer of the previous
  one is pending; hardware events arrive as one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
module io_space_address_decoder
(
  input wire logic core_clk,
  input wire logic rst,
  input wire io_space_pkg::io_request_type req,
  input wire logic [7:0] timer0_events,
  input wire logic [7:0] ext_irq_events,
  input wire logic [15:0] conv_result,
  output io_space_pkg::io_answer_type answer,
  output logic [7:0] ext_irq_mask_out
);
  import io_space_pkg::*;

  // Storage indexed by data-space address; unmapped entries stay zero
  logic [7:0] bank_reg [map_depth];
  io_answer_type answer_reg;
  logic [7:0] mask_out_reg;

  logic [7:0] data_addr;
  logic addr_ok;
  logic is_write;
  logic [7:0] cur_value;
  logic [7:0] write_value;
  logic [7:0] wmask;
  logic [7:0] cmask;
  logic mapped;
  // Descriptors of the two hardware-set flag registers
  reg_desc_type t0_desc;
  reg_desc_type ext_desc;

  // Find the descriptor of a data-space address
  function automatic reg_desc_type lookup(input logic [7:0] a);
    reg_desc_type d;
    d = '{8'h00, 8'h00, 8'h00};
    for (int i = 0; i < reg_count - 1; i++)
    begin
      if (reg_table[i].offset == a)
      begin
        d = reg_table[i];
      end
    end
    return d;
  endfunction : lookup

  // Is an address a known register (spare slot excluded)
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < reg_count - 1; i++)
    begin
      if (reg_table[i].offset == a)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_mapped

  // Address translation and access legality per instruction class
  always_comb
  begin
    data_addr = req.addr;
    addr_ok = 1'b0;
    is_write = 1'b0;
    unique case (req.kind)
      acc_none:
      begin
        addr_ok = 1'b0;
      end
      acc_short_in, acc_short_out:
      begin
        // Six-bit field: only the first 64 I/O slots exist
        data_addr = req.addr + io_to_data_offset;
        addr_ok = req.addr <= short_io_limit;
        is_write = req.kind == acc_short_out;
      end
      acc_bit_set, acc_bit_clear, acc_bit_test:
      begin
        data_addr = req.addr + io_to_data_offset;
        addr_ok = req.addr <= bit_access_limit;
        is_write = req.kind != acc_bit_test;
      end
      acc_data_load, acc_data_store:
      begin
        // Full byte address reaches the extended region too
        addr_ok = req.addr >= io_to_data_offset;
        is_write = req.kind == acc_data_store;
      end
    endcase
  end

  // Value that a write would store, before masking
  always_comb
  begin
    reg_desc_type d;
    d = lookup(data_addr);
    t0_desc = lookup(timer0_flags_offset);
    ext_desc = lookup(ext_irq_flags_offset);
    mapped = is_mapped(data_addr);
    wmask = d.write_mask;
    cmask = d.w1c_mask;
    cur_value = bank_reg[data_addr];
    unique case (req.kind)
      // Whole register read, one bit changed, written back
      acc_bit_set:
      begin
        write_value = cur_value | (8'h01 << req.bit_sel);
      end
      acc_bit_clear:
      begin
        write_value = cur_value & ~(8'h01 << req.bit_sel);
      end
      default:
      begin
        write_value = req.wdata;
      end
    endcase
  end

  // Register bank update; hardware sets outrank software clears
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < map_depth; i++)
      begin
        bank_reg[i] <= reset_value;
      end
    end
    else
    begin
      if (addr_ok && is_write && mapped)
      begin
        // Plain bits take the value; flags clear where a one lands
        bank_reg[data_addr] <= ((cur_value & ~wmask)
          | (write_value & wmask & ~cmask)
          | (cur_value & cmask & ~write_value)) & wmask;
      end
      bank_reg[timer0_flags_offset] <= (data_addr == timer0_flags_offset
        && addr_ok && is_write
        ? bank_reg[timer0_flags_offset] & ~write_value
        : bank_reg[timer0_flags_offset])
        | (timer0_events & t0_desc.w1c_mask);
      bank_reg[ext_irq_flags_offset] <= (data_addr == ext_irq_flags_offset
        && addr_ok && is_write
        ? bank_reg[ext_irq_flags_offset] & ~write_value
        : bank_reg[ext_irq_flags_offset])
        | (ext_irq_events & ext_desc.w1c_mask);
      // Read-only converter result tracks its source
      bank_reg[conv_low_offset] <= conv_result[7:0];
      bank_reg[conv_high_offset] <= conv_result[15:8];
    end
  end

  // Answer one cycle after the request
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      answer_reg <= '{1'b0, 8'h00, 1'b0, 1'b0};
    end
    else
    begin
      answer_reg.valid <= req.kind != acc_none;
      answer_reg.refused <= req.kind != acc_none && !addr_ok;
      // Unmapped slots and refused accesses read zero, gated by addr_ok and mapped
      answer_reg.rdata <= (addr_ok && mapped)
        ? bank_reg[data_addr] : 8'h00;
      answer_reg.bit_value <= addr_ok && req.kind == acc_bit_test
        && bank_reg[data_addr][req.bit_sel];
    end
  end

  // External interrupt mask mirrored out to steer the pin logic
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mask_out_reg <= 8'h00;
    end
    else
    begin
      mask_out_reg <= bank_reg[ext_irq_mask_offset];
    end
  end

  assign answer = answer_reg;
  assign ext_irq_mask_out = mask_out_reg;

  // Bit access above 0x1F is always refused
  chk_bit_range_refused: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind inside {acc_bit_set, acc_bit_clear, acc_bit_test}
     && req.addr > bit_access_limit) |=> answer.refused)
    else $error("bit access above 0x1F not refused");

  // Short forms above 0x3F are refused
  chk_short_range: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind inside {acc_short_in, acc_short_out} && req.addr > short_io_limit)
    |=> answer.valid && answer.refused)
    else $error("short access above 0x3F accepted");

  // Short read returns data at I/O address plus 0x20
  chk_short_offset: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_short_in && req.addr <= short_io_limit && mapped)
    |=> answer.rdata == $past(bank_reg[data_addr]))
    else $error("short read not at offset 0x20");

  // Test reports the selected bit
  chk_bit_test_val: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_bit_test && req.addr <= bit_access_limit)
    |=> answer.bit_value == $past(cur_value[req.bit_sel]))
    else $error("bit test value wrong");

  // Loads reach the extended region
  chk_ext_load: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_data_load && req.addr >= extended_base)
    |=> !answer.refused)
    else $error("extended load refused");

  // A one written to a flag clears it without an event
  chk_flag_w1c: assert property (@(posedge core_clk) disable iff (rst)
    (addr_ok && is_write && data_addr == ext_irq_flags_offset
     && write_value[0] && !ext_irq_events[0])
    |=> !bank_reg[ext_irq_flags_offset][0])
    else $error("flag not cleared by one");

  // An event wins over a simultaneous clear
  chk_flag_set_wins: assert property (@(posedge core_clk) disable iff (rst)
    ext_irq_events[0] |=> bank_reg[ext_irq_flags_offset][0])
    else $error("flag event lost");

  // Unmapped reads give zero
  chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_data_load && !mapped) |=> answer.rdata == 8'h00)
    else $error("unmapped read not zero");

  // Every request gets exactly one answer on the next edge
  chk_answer_pulse: assert property (@(posedge core_clk) disable iff (rst)
    req.kind != acc_none |=> answer.valid)
    else $error("request without answer");

  // Idle cycles give no answer, so the core never sees a stale one
  chk_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
    req.kind == acc_none |=> !answer.valid)
    else $error("answer without request");

  // A refusal never carries register data
  chk_refused_zero: assert property (@(posedge core_clk) disable iff (rst)
    answer.refused |-> answer.valid && answer.rdata == 8'h00)
    else $error("refused answer carries data");

  // Loads and stores below the I/O window are not ours
  chk_low_load_refused: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind inside {acc_data_load, acc_data_store}
     && req.addr < io_to_data_offset) |=> answer.refused)
    else $error("low data access accepted");

  // Short forms inside the six-bit field are accepted
  chk_short_ok: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind inside {acc_short_in, acc_short_out} && req.addr <= short_io_limit)
    |=> !answer.refused)
    else $error("legal short access refused");

  // Bit forms in the low 32 slots are accepted
  chk_bit_range_ok: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind inside {acc_bit_set, acc_bit_clear, acc_bit_test}
     && req.addr <= bit_access_limit) |=> !answer.refused)
    else $error("legal bit access refused");

  // A refused short write leaves its would-be target untouched
  chk_refused_no_write: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_short_out && !addr_ok && data_addr < conv_low_offset)
    |=> bank_reg[$past(data_addr)] == $past(bank_reg[data_addr]))
    else $error("refused write landed");

  // Bit set on a plain register leaves the bit at its writable level
  chk_bit_set_effect: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_bit_set && addr_ok && mapped && cmask == 8'h00)
    |=> bank_reg[$past(data_addr)][$past(req.bit_sel)]
        == $past(wmask[req.bit_sel]))
    else $error("bit set missed");

  // Bit clear on a plain register leaves the bit low
  chk_bit_clear_effect: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_bit_clear && addr_ok && mapped && cmask == 8'h00)
    |=> !bank_reg[$past(data_addr)][$past(req.bit_sel)])
    else $error("bit clear missed");

  // A bit test never alters a plain register
  chk_test_no_write: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_bit_test && mapped && cmask == 8'h00 && wmask != 8'h00)
    |=> bank_reg[$past(data_addr)] == $past(cur_value))
    else $error("bit test changed register");

  // A store to a plain register keeps only its writable bits
  chk_store_lands: assert property (@(posedge core_clk) disable iff (rst)
    (req.kind == acc_data_store && addr_ok && mapped && cmask == 8'h00
     && wmask != 8'h00)
    |=> bank_reg[$past(data_addr)] == ($past(req.wdata) & $past(wmask)))
    else $error("store did not land");

  // Timer flag events are never lost
  chk_timer_flag_set: assert property (@(posedge core_clk) disable iff (rst)
    timer0_events[0] |=> bank_reg[timer0_flags_offset][0])
    else $error("timer flag event lost");

  // Converter bytes follow their source one cycle late, writes or not
  chk_conv_track: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> bank_reg[conv_low_offset] == $past(conv_result[7:0])
      && bank_reg[conv_high_offset] == $past(conv_result[15:8]))
    else $error("converter byte stale");

  // Mask copy follows its register one cycle late
  chk_mask_copy: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> ext_irq_mask_out == $past(bank_reg[ext_irq_mask_offset]))
    else $error("mask copy stale");

  // Reserved bit positions never hold a one
  chk_reserved_bits: assert property (@(posedge core_clk) disable iff (rst)
    (data_addr != conv_low_offset && data_addr != conv_high_offset)
    |-> (bank_reg[data_addr] & ~wmask) == 8'h00)
    else $error("reserved bit set");

endmodule : io_space_address_decoder

// ### dv/core_access_model.sv
/*
  Core-side model: issues one access per call and notes its expected
  answer. Assumes the caller supplies the expected value with each call.
*/
`timescale 1ns/1ps
module core_access_model
(
  input wire logic core_clk,
  output io_space_pkg::io_request_type req
);
  import io_space_pkg::*;

  // Expected answers, oldest first: mode, refused, bit, rdata
  logic [11:0] notes [$];

  initial req = '{acc_none, 8'h00, 3'h0, 8'h00};

  // Request changes only on the edge; one edge per request
  task automatic issue(input access_kind_type k, input logic [7:0] a,
    input logic [2:0] b, input logic [7:0] d, input logic [11:0] n);
    @(posedge core_clk);
    req <= '{k, a, b, d};
    if (k != acc_none)
      notes.push_back(n);
  endtask : issue

  task automatic idle();
    issue(acc_none, 8'h00, 3'h0, 8'h00, 12'h000);
  endtask : idle

  task automatic st(input logic [7:0] a, input logic [7:0] d);
    issue(acc_data_store, a, 3'h0, d, 12'h800);
  endtask : st

  // Short form below the extended region, loads only above it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    if (a < extended_base)
      issue(acc_short_in, a - io_to_data_offset, 3'h0, 8'h00, {4'h0, e});
    else
      issue(acc_data_load, a, 3'h0, 8'h00, {4'h0, e});
  endtask : rd
endmodule : core_access_model

// ### dv/tb_io_space_address_decoder.sv
/*
  Self-checking bench for the I/O space decoder. Assumes the core model
  notes every expected answer before the answer can appear.
*/
`timescale 1ns/1ps
module tb_io_space_address_decoder;
  import io_space_pkg::*;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  io_request_type req;
  logic [7:0] timer0_events = 8'h00;
  logic [7:0] ext_irq_events = 8'h00;
  logic [15:0] conv_result = 16'h0000;
  io_answer_type answer;
  logic [7:0] ext_irq_mask_out;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] d;
  logic [11:0] note;

  always #12.5 core_clk = ~core_clk;

  io_space_address_decoder DUT
  (
    .core_clk(core_clk),
    .rst(rst),
    .req(req),
    .timer0_events(timer0_events),
    .ext_irq_events(ext_irq_events),
    .conv_result(conv_result),
    .answer(answer),
    .ext_irq_mask_out(ext_irq_mask_out)
  );

  core_access_model core
  (
    .core_clk(core_clk),
    .req(req)
  );

  task automatic check(input string what, input logic [7:0] e,
    input logic [7:0] s);
    n_checks++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", what, e, s);
      bad_count++;
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Event pulse lasting one cycle, with the core idle meanwhile
  task automatic pulse(input logic [7:0] t0, input logic [7:0] ex);
    core.idle();
    timer0_events <= t0;
    ext_irq_events <= ex;
    @(posedge core_clk);
    timer0_events <= 8'h00;
    ext_irq_events <= 8'h00;
  endtask : pulse

  // Each answer takes the oldest note; an unasked answer is a fault
  always @(negedge core_clk)
    if (answer.valid === 1'b1)
    begin
      if (core.notes.size() == 0)
        check("answer count", 8'h00, 8'h01);
      else
      begin
        note = core.notes.pop_front();
        check("refused", {7'h00, note[9]}, {7'h00, answer.refused});
        if (note[11:10] == 2'd0)
          check("rdata", note[7:0], answer.rdata);
        if (note[11:10] == 2'd1)
          check("bit", {7'h00, note[8]}, {7'h00, answer.bit_value});
      end
    end

  // Hang guard, far above the two hundred or so cycles the tests need
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    void'($urandom(19));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    conv_result <= {4'h0, 12'($urandom())};
    // Cleared after reset; converter bytes follow their input, ignore writes
    for (int i = 0; i < reg_count; i++)
      if (reg_table[i].write_mask != 8'h00)
        core.rd(reg_table[i].offset, 8'h00);
    core.st(conv_low_offset, 8'hFF);
    core.rd(conv_low_offset, conv_result[7:0]);
    core.rd(conv_high_offset, conv_result[15:8]);
    $display("test reset done");
    // Store by data address, read back by I/O address where short
    for (int i = 0; i < reg_count; i++)
      if (reg_table[i].write_mask != 8'h00)
      begin
        d = 8'($urandom());
        core.st(reg_table[i].offset, d & reg_table[i].write_mask);
        core.rd(reg_table[i].offset, d & reg_table[i].write_mask
          & ~reg_table[i].w1c_mask);
      end
    $display("test map done");
    // Illegal forms refused with zero data; reserved slots read zero
    // Reserved slots are never written; neighbours must not alias into them
    core.st(8'h28, 8'hFF);
    core.rd(8'h27, 8'h00);
    core.st(8'h62, 8'hFF);
    core.rd(8'h63, 8'h00);
    core.st(8'h60, 8'h00);
    core.st(8'h40, 8'h00);
    core.issue(acc_bit_set, 8'h20, 3'h0, 8'h00, 12'h200);
    core.issue(acc_bit_test, 8'h20, 3'h0, 8'h00, 12'h200);
    core.rd(8'h40, 8'h00);
    core.issue(acc_short_in, 8'h40, 3'h0, 8'h00, 12'h200);
    core.issue(acc_short_out, 8'h40, 3'h0, 8'hFF, 12'h200);
    core.rd(8'h60, 8'h00);
    core.st(8'h3F, 8'h00);
    core.issue(acc_bit_set, 8'h1F, 3'h5, 8'h00, 12'h800);
    core.rd(8'h3F, 8'h20);
    $display("test refuse done");
    // Bit access on a plain register, back to back
    core.st(8'h24, 8'h5A);
    core.issue(acc_bit_set, 8'h04, 3'h0, 8'h00, 12'h800);
    core.issue(acc_bit_clear, 8'h04, 3'h6, 8'h00, 12'h800);
    core.rd(8'h24, 8'h1B);
    core.issue(acc_bit_test, 8'h04, 3'h4, 8'h00, 12'h500);
    core.issue(acc_bit_test, 8'h04, 3'h2, 8'h00, 12'h400);
    $display("test bits done");
    // Flags clear on a written one; bit ops rewrite the whole register
    pulse(8'hFF, 8'h0F);
    core.rd(timer0_flags_offset, 8'h07);
    core.rd(ext_irq_flags_offset, 8'h0F);
    core.st(ext_irq_flags_offset, 8'h01);
    core.rd(ext_irq_flags_offset, 8'h0E);
    core.issue(acc_bit_clear, 8'h1C, 3'h3, 8'h00, 12'h800);
    core.rd(ext_irq_flags_offset, 8'h08);
    core.issue(acc_bit_test, 8'h1C, 3'h3, 8'h00, 12'h500);
    core.issue(acc_bit_set, 8'h1C, 3'h3, 8'h00, 12'h800);
    core.rd(ext_irq_flags_offset, 8'h00);
    $display("test flags done");
    // Mask copy keeps only its four defined bits
    core.st(8'h3D, 8'hA5);
    core.idle();
    repeat (2) @(negedge core_clk);
    check("irq mask", 8'h05, ext_irq_mask_out);
    $display("test mask done");
    repeat (3) @(negedge core_clk);
    check("pending", 8'h00, 8'(core.notes.size()));
    final_report();
  end
endmodule : tb_io_space_address_decoder
